// ### include/steer_pkg.sv
// package with register map, field positions and reset values for the pwm output steering block
package steer_pkg;

	// -----------------------------------------------------------------
	// register byte addresses
	// -----------------------------------------------------------------
	localparam logic [7:0] ccp_unit1_control_addr = 8'h00;
	localparam logic [7:0] ccp_unit2_control_addr = 8'h04;
	localparam logic [7:0] steering_control_addr  = 8'h08;
	localparam logic [7:0] pin_direction_addr     = 8'h0c;
	localparam logic [7:0] port_latch_addr        = 8'h10;
	localparam logic [7:0] steer_status_addr      = 8'h14;

	// -----------------------------------------------------------------
	// control register fields
	// -----------------------------------------------------------------
	localparam int         mode_lsb        = 0;
	localparam int         duty_lsb        = 4;
	localparam int         config_lsb      = 6;
	localparam logic [1:0] mode_pwm_upper  = 2'h3;
	localparam logic [1:0] config_single   = 2'h0;

	// -----------------------------------------------------------------
	// reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] control_reset   = 8'h00;
	localparam logic [3:0] steer_reset     = 4'h1;
	localparam logic [3:0] direction_reset = 4'hf;
	localparam logic [3:0] latch_reset     = 4'h0;

	// -----------------------------------------------------------------
	// ahb-lite encodings
	// -----------------------------------------------------------------
	localparam logic [1:0] htrans_nonseq   = 2'h2;
	localparam logic [1:0] htrans_seq      = 2'h3;
	localparam logic [2:0] hsize_word      = 3'h2;

	typedef logic [3:0] pin_vec_type;

endpackage : steer_pkg

// ### design/steer_pin_cell.sv
// one output pin: steering select, polarity, shutdown and direction for a single pin
module steer_pin_cell (
	input  wire logic sys_clk_i,    // system clock
	input  wire logic reset_i,      // async reset, high
	input  wire logic steer_on_i,   // steering mode active
	input  wire logic steer_en_i,   // this pin's steer enable
	input  wire logic pwm_i,        // raw pwm waveform
	input  wire logic invert_i,     // polarity select for this pin
	input  wire logic shutdown_i,   // auto-shutdown active
	input  wire logic shut_level_i, // level a shut pin is forced to
	input  wire logic latch_i,      // port latch bit
	input  wire logic dir_out_i,    // direction bit (0 = output)
	output logic      pin_o,        // pin level
	output logic      pin_oe_o      // pin driver enable
);

	typedef struct packed {
		logic pin;
		logic oe;
	} cell_type;

	cell_type state;
	cell_type next_state;

	// -----------------------------------------------------------------
	// pin mux
	// -----------------------------------------------------------------
	// a pin not steered stays with the port latch so firmware keeps full control
	always_comb begin
		next_state     = state;
		next_state.oe  = ~dir_out_i;
		if (steer_on_i && steer_en_i) begin
			if (shutdown_i) begin
				next_state.pin = shut_level_i;           // [RULE5]
			end else begin
				next_state.pin = pwm_i ^ invert_i;       // [RULE2] [RULE3]
			end
		end else begin
			next_state.pin = latch_i;                   // [RULE7]
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pin_o    = state.pin;
	assign pin_oe_o = state.oe;

endmodule : steer_pin_cell

// ### design/pwm_output_steering.sv
// pwm output steering stage: ahb-lite registers and four steered pwm pins
// Function
// (RULE1) steering applies only when the mode field upper bits are 11 and the output config field is 00.
// (RULE2) the same pwm waveform goes to every pin A to D whose steer enable bit is set.
// (RULE3) the mode field low two bits choose the output polarity of the steered pins.
// (RULE4) software sets a pin's direction bit to 0 so its driver is enabled.
// (RULE5) auto-shutdown still works in steering mode and only touches steered pins.
// (RULE6) software sets at least one steer enable bit to get any pwm output.
// (RULE7) a pin whose steer enable is clear carries the port latch value, not pwm.
//
// Our own choices: the AHB-Lite register port and the register offsets.
module pwm_output_steering
	import steer_pkg::*;
(
	input  wire logic                   sys_clk_i,    // system clock, 50 MHz
	input  wire logic                   reset_i,      // async reset, high
	input  wire logic                   hsel_i,       // ahb slave select
	input  wire logic [7:0]             haddr_i,      // ahb address
	input  wire logic [1:0]             htrans_i,     // ahb transfer type
	input  wire logic                   hwrite_i,     // ahb write
	input  wire logic [2:0]             hsize_i,      // ahb size
	input  wire logic [31:0]            hwdata_i,     // ahb write data
	input  wire logic                   hready_i,     // ahb bus ready
	output logic      [31:0]            hrdata_o,     // ahb read data
	output logic                        hreadyout_o,  // ahb slave ready
	output logic                        hresp_o,      // ahb response
	input  wire logic                   pwm_unit1_i,  // unit 1 pwm waveform
	input  wire logic                   pwm_unit2_i,  // unit 2 pwm waveform
	input  wire logic                   shutdown_i,   // auto-shutdown request
	output steer_pkg::pin_vec_type      pwm_pins_o,   // output pins A..D
	output steer_pkg::pin_vec_type      pwm_pins_oe_o // output enables A..D
);

	import steer_pkg::*;

	typedef struct packed {
		logic [7:0]  unit1_ctrl;
		logic [7:0]  unit2_ctrl;
		logic [3:0]  steer_en;
		logic [3:0]  direction;
		logic [3:0]  latch;
		logic        wr_pend;
		logic [7:0]  wr_addr;
		logic [31:0] rdata;
	} regs_type;

	regs_type r;
	regs_type next_r;

	logic        steer_on;
	logic [1:0]  polarity;
	logic        shut_level;
	logic [31:0] read_mux;
	logic        access;

	// -----------------------------------------------------------------
	// mode decode
	// -----------------------------------------------------------------
	// only unit 1 feeds the pins; unit 2 registers are kept for software
	assign steer_on = (r.unit1_ctrl[mode_lsb+3 -: 2] == mode_pwm_upper) &&
		(r.unit1_ctrl[config_lsb +: 2] == config_single);            // [RULE1]
	assign polarity = r.unit1_ctrl[mode_lsb +: 2];                     // [RULE3]
	// shut pins all go to polarity bit 0, the inactive level of pins B and D
	assign shut_level = polarity[0];                                    // [RULE5]

	// -----------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// -----------------------------------------------------------------
	assign access = hsel_i && hready_i && (htrans_i == htrans_nonseq || htrans_i == htrans_seq);

	// read data registered in the address phase so hrdata comes from a flop
	always_comb begin
		read_mux = 32'h0;
		if (haddr_i == ccp_unit1_control_addr) begin
			read_mux = {24'h0, r.unit1_ctrl};
		end else if (haddr_i == ccp_unit2_control_addr) begin
			read_mux = {24'h0, r.unit2_ctrl};
		end else if (haddr_i == steering_control_addr) begin
			read_mux = {28'h0, r.steer_en};
		end else if (haddr_i == pin_direction_addr) begin
			read_mux = {28'h0, r.direction};
		end else if (haddr_i == port_latch_addr) begin
			read_mux = {28'h0, r.latch};
		end else if (haddr_i == steer_status_addr) begin
			read_mux = {27'h0, shutdown_i, pwm_pins_oe_o == 4'h0, steer_on, r.steer_en != 4'h0, pwm_unit1_i};
		end else begin
			read_mux = 32'h0;
		end
	end

	// register writes land in the data phase
	always_comb begin
		next_r         = r;
		next_r.wr_pend = access && hwrite_i;
		if (access) begin
			next_r.wr_addr = haddr_i;
		end
		if (access && !hwrite_i) begin
			next_r.rdata = read_mux;
		end
		if (r.wr_pend) begin
			if (r.wr_addr == ccp_unit1_control_addr) begin
				next_r.unit1_ctrl = hwdata_i[7:0];
			end else if (r.wr_addr == ccp_unit2_control_addr) begin
				next_r.unit2_ctrl = hwdata_i[7:0];
			end else if (r.wr_addr == steering_control_addr) begin
				next_r.steer_en = hwdata_i[3:0];      // [RULE6]
			end else if (r.wr_addr == pin_direction_addr) begin
				next_r.direction = hwdata_i[3:0];     // [RULE4]
			end else if (r.wr_addr == port_latch_addr) begin
				next_r.latch = hwdata_i[3:0];
			end
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			r.unit1_ctrl <= control_reset;
			r.unit2_ctrl <= control_reset;
			r.steer_en   <= steer_reset;
			r.direction  <= direction_reset;
			r.latch      <= latch_reset;
			r.wr_pend    <= 1'b0;
			r.wr_addr    <= 8'h00;
			r.rdata      <= 32'h0;
		end else begin
			r <= next_r;
		end
	end

	assign hrdata_o    = r.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// -----------------------------------------------------------------
	// pin cells
	// -----------------------------------------------------------------
	// polarity bit 1 inverts A and C, bit 0 inverts B and D
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_pin
			steer_pin_cell u_cell (
				.sys_clk_i    (sys_clk_i),
				.reset_i      (reset_i),
				.steer_on_i   (steer_on),
				.steer_en_i   (r.steer_en[i]),               // [RULE2]
				.pwm_i        (pwm_unit1_i),
				.invert_i     (i % 2 == 0 ? polarity[1] : polarity[0]),
				.shutdown_i   (shutdown_i),
				.shut_level_i (shut_level),
				.latch_i      (r.latch[i]),
				.dir_out_i    (r.direction[i]),
				.pin_o        (pwm_pins_o[i]),
				.pin_oe_o     (pwm_pins_oe_o[i])
			);
		end
	endgenerate

endmodule : pwm_output_steering

// ### tb/steer_load_model.sv
// load model: the level each pwm pin presents to the external circuit
module steer_load_model
	import steer_pkg::*;
(
	input  wire steer_pkg::pin_vec_type pins_i,  // pin levels
	input  wire steer_pkg::pin_vec_type oe_i,    // driver enables
	output steer_pkg::pin_vec_type      level_o  // level at the load
);
	timeunit 1ns;
	timeprecision 1ps;
	// a released pin is held low by the load's pull-down
	assign level_o = pins_i & oe_i;
endmodule : steer_load_model

// ### tb/pwm_steer_sva.sv
// checker: pin behaviour against a shadow copy of the written registers
module pwm_steer_sva
	import steer_pkg::*;
(
	input wire logic        sys_clk_i,   // clock
	input wire logic        reset_i,     // reset
	input wire logic        hsel_i,      // select
	input wire logic [7:0]  haddr_i,     // address
	input wire logic [1:0]  htrans_i,    // type
	input wire logic        hwrite_i,    // write
	input wire logic [31:0] hwdata_i,    // data
	input wire logic        hready_i,    // ready
	input wire logic        pwm_unit1_i, // waveform
	input wire logic        shutdown_i,  // shutdown
	input wire steer_pkg::pin_vec_type pwm_pins_o,   // pins
	input wire steer_pkg::pin_vec_type pwm_pins_oe_o // enables
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] c1, wa;
	logic [3:0] st, dr, lt;
	logic       wv;
	// shadow registers land when the data phase ends, same as the design
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			{c1, st, dr, lt, wv, wa} <= {control_reset, steer_reset, direction_reset, latch_reset, 9'h000};
		end else begin
			wv <= hsel_i & hready_i & htrans_i[1] & hwrite_i;
			wa <= haddr_i;
			if (wv && wa == ccp_unit1_control_addr) c1 <= hwdata_i[7:0];
			if (wv && wa == steering_control_addr) st <= hwdata_i[3:0];
			if (wv && wa == pin_direction_addr) dr <= hwdata_i[3:0];
			if (wv && wa == port_latch_addr) lt <= hwdata_i[3:0];
		end
	end
	wire       act = c1[3:2] == mode_pwm_upper && c1[7:6] == config_single;
	wire [3:0] sm  = act ? st : 4'h0;
	wire [3:0] inv = {c1[0], c1[1], c1[0], c1[1]};
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	AST_OFF_MODE_LATCH: assert property (!$past(act) |-> pwm_pins_o == $past(lt))
		else $error("pins left latch control outside single mode");
	AST_SAME_WAVE: assert property ($past(act & ~shutdown_i & pwm_unit1_i) |->
		((pwm_pins_o ^ ~$past(inv)) & $past(sm)) == 4'h0)
		else $error("steered pins differ from the waveform");
	AST_POLARITY: assert property ($past(act & ~shutdown_i & ~pwm_unit1_i) |->
		(pwm_pins_o & $past(sm)) == ($past(inv) & $past(sm)))
		else $error("steered pin polarity wrong");
	AST_SHUTDOWN_STEERED: assert property ($past(act & shutdown_i) |->
		(pwm_pins_o & $past(sm)) == ({4{$past(c1[0])}} & $past(sm)))
		else $error("shutdown level wrong on steered pin");
	AST_UNSTEERED_LATCH: assert property ((pwm_pins_o & ~$past(sm)) == ($past(lt) & ~$past(sm)))
		else $error("unsteered pin not at latch value");
	AST_DRIVER_ENABLE: assert property (pwm_pins_oe_o == ~$past(dr))
		else $error("driver enable not the inverse of direction");
	cover property (act && shutdown_i && st != 4'h0);
	cover property (act && st == 4'hf);
	cover property (wv && wa == steering_control_addr);
endmodule : pwm_steer_sva

bind pwm_output_steering pwm_steer_sva u_sva (.sys_clk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
	.hwdata_i, .hready_i, .pwm_unit1_i, .shutdown_i, .pwm_pins_o, .pwm_pins_oe_o);

// ### tb/pwm_output_steering_bench.sv
// bench: random register setups and pin levels against a behavioural model
module pwm_output_steering_bench
	import steer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, hsel = 0, hwrite = 0, pwm = 0, pwm2 = 0, sd = 0, rdy, resp;
	logic [7:0] haddr = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 0;
	logic [31:0] hwdata = 0, hrdata, q;
	pin_vec_type pins, oe, lvl;
	int fail_count = 0, checked = 0, ctrl, steer, dir, latch;
	logic [7:0] raddr [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
	logic [31:0] rval [6] = '{32'(control_reset), 32'(control_reset), 32'(steer_reset), 32'(direction_reset),
		32'(latch_reset), 32'h0};
	always #10 clk = ~clk;
	pwm_output_steering dut (.sys_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(rdy), .hrdata_o(hrdata),
		.hreadyout_o(rdy), .hresp_o(resp), .pwm_unit1_i(pwm), .pwm_unit2_i(pwm2), .shutdown_i(sd),
		.pwm_pins_o(pins), .pwm_pins_oe_o(oe));
	steer_load_model u_load (.pins_i(pins), .oe_i(oe), .level_o(lvl));
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// bounded wait for hready high at a rising edge
	task wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		if (n >= 50) begin
			fail_count++;
			tally_and_finish;
		end
	endtask : wait_rdy
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1; haddr <= a; hwrite <= w; htrans <= htrans_nonseq; hsize <= hsize_word;
		wait_rdy;
		hsel <= 0; htrans <= 2'h0; hwdata <= d;
		wait_rdy;
		q = hrdata;
	endtask : bus
	// expected level at the load: steered pins carry the polarised wave, or ctrl bit 0 during shutdown
	function logic [3:0] model_pins(input logic p, input logic s);
		logic [3:0] r;
		for (int i = 0; i < 4; i++) begin
			if (!(ctrl[3:2] == 3 && ctrl[7:6] == 0 && steer[i])) r[i] = latch[i];
			else r[i] = s ? ctrl[0] : p ^ ctrl[(i + 1) % 2];
		end
		return r & ~dir[3:0];
	endfunction : model_pins
	initial begin
		ctrl = $urandom(26);
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			bus(0, raddr[i], 0);
			check(q, rval[i]);
		end
		for (int i = 0; i < 64; i++) begin
			ctrl = $urandom & 8'hff;
			if (i % 2) ctrl = (ctrl & 8'h30) | 8'h0c | (i / 2 % 4);
			steer = $urandom % 16;
			latch = $urandom % 16;
			dir = i < 8 ? 0 : $urandom % 16;
			bus(1, ccp_unit1_control_addr, ctrl);
			bus(1, ccp_unit2_control_addr, $urandom);
			bus(1, steering_control_addr, steer);
			bus(1, port_latch_addr, latch);
			bus(1, pin_direction_addr, dir);
			bus(0, ccp_unit1_control_addr, 0);
			check(q, ctrl);
			for (int k = 0; k < 4; k++) begin
				pwm <= k[0]; sd <= k[1]; pwm2 <= $urandom;
				repeat (2) @(posedge clk);
				check(lvl, model_pins(k[0], k[1]));
				check(oe, {28'h0, ~dir[3:0]});
			end
			bus(0, steer_status_addr, 0);
			check(q, {27'h0, 1'b1, dir[3:0] == 4'hf, ctrl[3:2] == 3 && ctrl[7:6] == 0, steer[3:0] != 0, 1'b1});
		end
		tally_and_finish;
	end
endmodule : pwm_output_steering_bench
